// ===== common/wtu_pkg.sv
/*
  constants for the watchdog timeout unit: register map, field layout,
  reset values, bus answers and the selector to exponent mapping.
  assumes a 32-bit AXI4-Lite register bus.
*/
package wtu_pkg;

  // bus widths and answers
  localparam int         DATA_W      = 32;
  localparam int         ADDR_W      = 32;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register byte addresses
  localparam logic [ADDR_W-1:0] TIMER_IRQ_CLEAR_ADDR  = 32'hF0040004;
  localparam logic [ADDR_W-1:0] WATCHDOG_CONTROL_ADDR = 32'hF0040008;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR       = 32'hF0040040;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR       = 32'hF0040044;
  localparam logic [ADDR_W-1:0] WDOG_COUNT_ADDR       = 32'hF0040048;

  // watchdog_control fields
  localparam int                ARM_BIT    = 31;
  localparam int                CLR_BIT    = 29;
  localparam int                SEL_LSB    = 0;
  localparam int                SEL_W      = 17;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] CTRL_WMASK = 32'hA001FFFF;

  // interrupt status / enable / clear share this bit
  localparam int   WDOG_IRQ_BIT = 6;
  localparam logic STAT_RESET   = 1'h0;
  localparam logic EN_RESET     = 1'h0;

  // timeout counter and selector exponents
  localparam int CNT_W        = 30;
  localparam int EXP_BASE     = 9;
  localparam int EXP_STEP     = 3;
  localparam int EXP_FAST_N   = 3;
  localparam int EXP_TAIL_OFS = 14;

  // log2 of the timeout length in clocks for a selector index
  function automatic int wtu_sel_exp(input int idx);
    return (idx < EXP_FAST_N) ? EXP_BASE + EXP_STEP * idx : idx + EXP_TAIL_OFS;
  endfunction

endpackage

// ===== hdl/wtu_lowbit.sv
/*
  lowest set bit finder for the timeout selector.
  assumes a purely combinational use on the caller's clock.
*/
`timescale 1ns/1ps

module wtu_lowbit #(
  parameter int W  = 17,
  parameter int IW = 5
) (
  input  wire logic [W-1:0]  vec,
  output      logic [IW-1:0] idx,
  output      logic          vld
);

  // refuse an index too narrow for the vector
  if (W < 1 || (1 << IW) < W) begin : g_bad_width
    $error("wtu_lowbit: index too narrow");
  end

  // scan downward so the lowest set bit is written last
  always_comb begin
    idx = '0;
    vld = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = IW'(i);
        vld = 1'b1;
      end
    end
  end

endmodule // wtu_lowbit

// ===== hdl/wtu_top.sv
/*
  watchdog timeout unit: control register, timeout counter, sticky
  interrupt and an AXI4-Lite slave for the registers.
  assumes one 100 MHz clock, synchronous active high reset, and a bus
  master that keeps one read and one write outstanding at most.
*/
`timescale 1ns/1ps

// Behaviour
// - watchdog counts only after software sets the arm bit 31.
// - arm bit with clear bit 29 set resets the timeout counter.
// - clear bit 29 drops by itself after the clearing cycle.
// - several selector bits set: lowest one decides the timeout.
// - selector bits 16..0 all zero: no timeout at all.
// - each selector bit picks a power-of-two count of bus clocks.
// - pending watchdog interrupt cleared through the shared timer clear register.
module wtu_top
  import wtu_pkg::*;
#(
  parameter int EXP_OFS = 0
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [DATA_W-1:0] s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output      logic              wdog_timeout,
  output      logic              irq
);

  localparam int IDX_W = $clog2(SEL_W);

  if (EXP_OFS < 0 || EXP_OFS >= EXP_BASE) begin : g_bad_ofs
    $error("wtu_top: EXP_OFS out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic              awready_ff, nxt_awready;
  logic              wready_ff, nxt_wready;
  logic              aw_got_ff, nxt_aw_got;
  logic              w_got_ff, nxt_w_got;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [DATA_W-1:0] wdata_ff, nxt_wdata;
  logic [3:0]        wstrb_ff, nxt_wstrb;
  logic              bvalid_ff, nxt_bvalid;
  logic [1:0]        bresp_ff, nxt_bresp;
  logic              arready_ff, nxt_arready;
  logic              rvalid_ff, nxt_rvalid;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [1:0]        rresp_ff, nxt_rresp;
  logic [DATA_W-1:0] ctrl_ff, nxt_ctrl;
  logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
  logic              tmo_ff, nxt_tmo;
  logic              stat_ff, nxt_stat;
  logic              en_ff, nxt_en;
  logic              irq_ff, nxt_irq;
  logic              wr_fire;
  logic              wr_ctrl, wr_clr, wr_en, wr_ok;
  logic              clr_hit;
  logic [DATA_W-1:0] wr_mask;
  logic [SEL_W-1:0]  sel;
  logic [IDX_W-1:0]  sel_idx;
  logic              sel_vld;
  int                sel_exp;
  logic [CNT_W-1:0]  lim;
  logic              armed, do_clr;

  ////////////////////////////////////////////////////////////////////////
  // write address and data, taken in either order

  assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_ctrl = wr_fire && (awaddr_ff == WATCHDOG_CONTROL_ADDR);
  assign wr_clr  = wr_fire && (awaddr_ff == TIMER_IRQ_CLEAR_ADDR);
  assign wr_en   = wr_fire && (awaddr_ff == IRQ_ENABLE_ADDR);
  assign wr_ok   = wr_ctrl || wr_clr || wr_en || (awaddr_ff == IRQ_STATUS_ADDR)
                   || (awaddr_ff == WDOG_COUNT_ADDR);

  // byte enables widened to a bit mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_mask[b*8 +: 8] = {8{wstrb_ff[b]}};
    end
  end

  // capture each channel, answer once both are held
  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got  = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    nxt_awready = !nxt_aw_got && !nxt_bvalid;
    nxt_wready  = !nxt_w_got && !nxt_bvalid;
  end

  // write channel registers
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= '0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
    end else begin
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      awaddr_ff  <= nxt_awaddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read channel, one cycle from address to data

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = RESP_OKAY;
      nxt_rdata  = '0;
      unique case (s_axi_araddr)
        WATCHDOG_CONTROL_ADDR: nxt_rdata = ctrl_ff;
        IRQ_STATUS_ADDR:       nxt_rdata[WDOG_IRQ_BIT] = stat_ff;
        IRQ_ENABLE_ADDR:       nxt_rdata[WDOG_IRQ_BIT] = en_ff;
        WDOG_COUNT_ADDR:       nxt_rdata[CNT_W-1:0] = cnt_ff;
        TIMER_IRQ_CLEAR_ADDR:  nxt_rdata = '0; // write-only, reads zero
        default:               nxt_rresp = RESP_SLVERR;
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    nxt_arready = !nxt_rvalid;
  end

  // read channel registers
  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= RESP_OKAY;
      arready_ff <= 1'b0;
    end else begin
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
      arready_ff <= nxt_arready;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register and selector

  assign armed  = ctrl_ff[ARM_BIT];
  assign do_clr = armed && ctrl_ff[CLR_BIT];
  assign sel    = ctrl_ff[SEL_LSB +: SEL_W];

  // lowest selector bit wins
  wtu_lowbit #(
    .W  (SEL_W),
    .IW (IDX_W)
  ) u_wtu_lowbit (
    .vec (sel),
    .idx (sel_idx),
    .vld (sel_vld)
  );

  // limit of a power of two minus one for the chosen bit
  always_comb begin
    sel_exp = wtu_sel_exp(int'(sel_idx)) - EXP_OFS;
    lim     = {CNT_W{1'b1}} >> (CNT_W - sel_exp);
  end

  // clear bit self-drops, software write overrides
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (do_clr) begin
      nxt_ctrl[CLR_BIT] = 1'b0;
    end
    if (wr_ctrl) begin
      nxt_ctrl = (ctrl_ff & ~(wr_mask & CTRL_WMASK)) | (wdata_ff & wr_mask & CTRL_WMASK);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_ff <= CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timeout counter

  // clear first, then count while armed with a selector
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_tmo = 1'b0;
    if (do_clr) begin
      nxt_cnt = '0;
    end else if (armed && sel_vld) begin
      if (cnt_ff == lim) begin
        nxt_cnt = '0;
        nxt_tmo = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff <= '0;
      tmo_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tmo_ff <= nxt_tmo;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status, enable, interrupt level

  assign clr_hit = wr_clr && wstrb_ff[WDOG_IRQ_BIT/8] && wdata_ff[WDOG_IRQ_BIT];

  // a timeout in the clearing cycle wins
  always_comb begin
    nxt_stat = stat_ff;
    nxt_en   = en_ff;
    if (clr_hit) begin
      nxt_stat = 1'b0;
    end
    if (tmo_ff) begin
      nxt_stat = 1'b1;
    end
    if (wr_en && wstrb_ff[WDOG_IRQ_BIT/8]) begin
      nxt_en = wdata_ff[WDOG_IRQ_BIT];
    end
    nxt_irq = nxt_stat && nxt_en;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stat_ff <= STAT_RESET;
      en_ff   <= EN_RESET;
      irq_ff  <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      en_ff   <= nxt_en;
      irq_ff  <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign wdog_timeout  = tmo_ff;
  assign irq           = irq_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_disarm_hold: assert property (!armed |=> $stable(cnt_ff) && !tmo_ff)
    else $error("counter moved while disarmed");

  chk_clear_zero: assert property (do_clr |=> cnt_ff == '0)
    else $error("counter not cleared");

  chk_clear_drop: assert property (do_clr && !wr_ctrl |=> !ctrl_ff[CLR_BIT])
    else $error("clear bit stuck");

  chk_low_bit: assert property (sel_vld |-> sel[sel_idx] && ((sel & ((SEL_W'(1) << sel_idx) - 1'b1)) == '0))
    else $error("selector not lowest bit");

  chk_no_sel: assert property (sel == '0 |=> !tmo_ff)
    else $error("timeout with empty selector");

  chk_tmo_limit: assert property (tmo_ff |-> $past(cnt_ff) == $past(lim) && cnt_ff == '0)
    else $error("timeout at wrong count");

  chk_irq_clear: assert property (clr_hit && !tmo_ff |=> !stat_ff && !irq_ff)
    else $error("interrupt not cleared");

  chk_count_step: assert property (armed && sel_vld && !do_clr && cnt_ff != lim
                                   |=> cnt_ff == $past(cnt_ff) + 1'b1)
    else $error("counter did not step");

  chk_tmo_sets: assert property (tmo_ff |=> stat_ff)
    else $error("timeout not latched");

  chk_bvalid_hold: assert property (bvalid_ff && !s_axi_bready |=> bvalid_ff && $stable(bresp_ff))
    else $error("write answer dropped");

endmodule // wtu_top

// ===== verification/wtu_top_bench.sv
/*
  self-checking bench for wtu_top: axi4-lite master tasks, queued
  expectations checked by a monitor, watchdog and interrupt scenarios.
  assumes wtu_pkg and the design assertions compiled alongside.
*/
`timescale 1ns/1ps

module wtu_top_bench;
  import wtu_pkg::*;

  localparam int OFS = 6; // bit0 gives 8 clocks

  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0]        wstrb = 4'hF;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, wdog_timeout, irq;
  logic [1:0]        bresp, rresp;
  logic [DATA_W-1:0] rdata, d, sel;
  logic [33:0]       rq[$];
  logic [1:0]        bq[$];
  int                gq[$];
  int                errors = 0, samples_checked = 0, cyc = 0, gap = 0, pulses = 0, p0, seed = 21;

  // clock
  always #5 clk = ~clk;

  wtu_top #(.EXP_OFS(OFS)) u_wtu_top (
    .clk(clk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wdog_timeout(wdog_timeout), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////
  // compare and verdict
  task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // log2 of timeout length for selector index
  function automatic int bexp(input int k);
    return (k == 0) ? 9 : (k == 1) ? 12 : (k == 2) ? 15 : k + 14;
  endfunction

  ////////////////////////////////////////////////////////////////
  // bus tasks, entered and left at a rising edge
  task automatic wr(input logic [31:0] a, input logic [31:0] dat, input logic [1:0] rsp);
    logic aw_open, w_open;
    aw_open = 1'b1;
    w_open  = 1'b1;
    bq.push_back(rsp);
    awaddr  <= a;
    wdata   <= dat;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (aw_open || w_open) begin
      @(posedge clk);
      if (aw_open && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_open = 1'b0;
      end
      if (w_open && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_open = 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] dat, input logic [1:0] rsp);
    rq.push_back({rsp, dat});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // wait for one expiry pulse, bounded
  task automatic wait_pulse;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wdog_timeout !== 1'b1 && n < 5000);
    check(wdog_timeout, 1'b1, "pulse");
    @(posedge clk);
  endtask

  task automatic chk_irq(input logic exp);
    repeat (3) @(posedge clk);
    check(irq, exp, "irq");
  endtask

  ////////////////////////////////////////////////////////////////
  // monitor: takes the oldest note whenever a result appears
  always @(posedge clk) begin
    cyc++;
    gap++;
    if (cyc == 40000) begin
      errors++;
      stop_test();
    end
    if (wdog_timeout === 1'b1) begin
      pulses++;
      if (gq.size() > 0) check(gap, gq.pop_front(), "timeout gap");
      gap = 0;
    end
    if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0) check({rresp, rdata}, rq.pop_front(), "read");
    if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0) check(bresp, bq.pop_front(), "bresp");
  end

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(WATCHDOG_CONTROL_ADDR, CTRL_RESET, RESP_OKAY);
    rd(IRQ_STATUS_ADDR, 32'h0, RESP_OKAY);
    rd(IRQ_ENABLE_ADDR, 32'h0, RESP_OKAY);
    rd(32'hF0040100, 32'h0, RESP_SLVERR);
    wr(32'hF0040100, 32'hFFFFFFFF, RESP_SLVERR);
    // random disarmed settings: stored, but nothing counts
    repeat (4) begin
      d = $random(seed) & 32'h7FFFFFFF;
      wr(WATCHDOG_CONTROL_ADDR, d, RESP_OKAY);
      rd(WATCHDOG_CONTROL_ADDR, d & CTRL_WMASK, RESP_OKAY);
    end
    // low two byte strobes only: upper bytes, arm bit included, keep their value
    wstrb <= 4'h3;
    wr(WATCHDOG_CONTROL_ADDR, 32'hFFFFFFFF, RESP_OKAY);
    wstrb <= 4'hF;
    rd(WATCHDOG_CONTROL_ADDR, (d & CTRL_WMASK & 32'hFFFF0000) | 32'h0000FFFF, RESP_OKAY);
    repeat (50) @(posedge clk);
    check(pulses, 0, "disarmed pulses");
    wr(IRQ_ENABLE_ADDR, 32'h40, RESP_OKAY);
    // lowest set selector bit decides, higher bits random
    for (int k = 0; k < 5; k++) begin
      sel = ((($random(seed) << 1) | 32'h1) << k) & 32'h1FFFF;
      wr(WATCHDOG_CONTROL_ADDR, 32'hA0000000 | sel, RESP_OKAY);
      wait_pulse();
      gq.push_back(1 << (bexp(k) - OFS));
      wait_pulse();
    end
    chk_irq(1'b1);
    // disarm, mask, unmask, clear
    wr(WATCHDOG_CONTROL_ADDR, 32'h00000001, RESP_OKAY);
    wr(IRQ_ENABLE_ADDR, 32'h0, RESP_OKAY);
    chk_irq(1'b0);
    rd(IRQ_STATUS_ADDR, 32'h40, RESP_OKAY);
    wr(IRQ_ENABLE_ADDR, 32'h40, RESP_OKAY);
    chk_irq(1'b1);
    wr(TIMER_IRQ_CLEAR_ADDR, 32'h40, RESP_OKAY);
    rd(IRQ_STATUS_ADDR, 32'h0, RESP_OKAY);
    chk_irq(1'b0);
    // arm with clear and empty selector: counter zeroed, clear bit drops
    p0 = pulses;
    wr(WATCHDOG_CONTROL_ADDR, 32'hA0000000, RESP_OKAY);
    rd(WDOG_COUNT_ADDR, 32'h0, RESP_OKAY);
    rd(WATCHDOG_CONTROL_ADDR, 32'h80000000, RESP_OKAY);
    repeat (300) @(posedge clk);
    check(pulses, p0, "idle pulses");
    rd(WDOG_COUNT_ADDR, 32'h0, RESP_OKAY);
    stop_test();
  end

endmodule // wtu_top_bench
